// ---- core/auto_offset_gain_calibration.sv ----
// Automatic offset and gain matching control for a triple video converter
`timescale 1ns/10ps
`default_nettype none
module auto_offset_gain_calibration (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic reg_wr,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	input wire logic clamp_pin,
	input wire logic clamp_internal,
	input wire logic [2:0][9:0] adc_data,
	output logic [2:0][9:0] data_out,
	output logic [2:0][10:0] offset_adj,
	output logic [2:0][7:0] gain_trim,
	output logic [2:0] clamp_midscale,
	output logic clamp_active,
	output logic cal_busy
);
	typedef struct packed {
		cal_pkg::cal_state_t st;
		logic [3:0] cnt;
		logic [cal_pkg::reg_count-1:0][7:0] regs;
		logic [7:0] rdata;
		logic pin_meta;
		logic pin_sync;
		logic clamp_prev;
		logic [8:0] lines;
		logic run_off;
		logic run_gain;
		logic [2:0][10:0] off_auto;
		logic [2:0][10:0] off_out;
		logic [2:0][7:0] gain;
		logic [2:0][9:0] dout;
	} cal_state_s_t;

	cal_state_s_t state;
	cal_state_s_t next_state;
	cal_avg_if avg_bus ();

	// ==========================================
	// Helpers
	function automatic logic [4:0] addr_lookup(input logic [7:0] a);
		logic [4:0] r;
		r = 5'h00;
		for (int i = 0; i < cal_pkg::reg_count; i++) begin
			if (cal_pkg::reg_addr_map[i] == a) begin
				r = {1'b1, i[3:0]};
			end
		end
		return r;
	endfunction : addr_lookup

	function automatic logic [10:0] target_code(input logic [7:0] up,
			input logic [7:0] lo);
		return {up, lo[7:5]};
	endfunction : target_code

	function automatic logic [10:0] manual_code(input logic [7:0] up,
			input logic [7:0] lo);
		return {{2{up[6]}}, up[6:0], lo[7:6]};
	endfunction : manual_code

	function automatic logic [10:0] sat11(input logic signed [12:0] v);
		if (v > 13'sd1023) begin
			return 11'h3ff;
		end else if (v < -13'sd1024) begin
			return 11'h400;
		end
		return v[10:0];
	endfunction : sat11

	logic [7:0] off_ctl;
	logic [7:0] gain_ctl;
	logic clamp_now;
	logic clamp_end;
	logic off_enabled;
	logic off_run;
	logic gain_run;
	logic [8:0] interval;
	logic freeze;

	assign off_ctl = state.regs[cal_pkg::idx_off_ctl];
	assign gain_ctl = state.regs[cal_pkg::idx_gain_ctl];
	assign off_enabled = off_ctl[cal_pkg::auto_offset_bit];
	assign off_run = off_enabled
		&& !state.regs[cal_pkg::idx_off_hold][cal_pkg::offset_hold_bit];
	assign gain_run = gain_ctl[2:0] == cal_pkg::gain_enable_code
		&& !gain_ctl[cal_pkg::gain_hold_bit];
	assign clamp_now = state.regs[cal_pkg::idx_clamp_sel][cal_pkg::clamp_src_bit]
		? state.pin_sync : clamp_internal;
	assign clamp_end = state.clamp_prev && !clamp_now;
	assign freeze = state.st == cal_pkg::st_window && state.run_gain;

	always_comb begin
		unique case (off_ctl[cal_pkg::rate_lsb +: 2])
			2'b00: interval = cal_pkg::interval_00;
			2'b01: interval = cal_pkg::interval_01;
			2'b10: interval = cal_pkg::interval_10;
			2'b11: interval = cal_pkg::interval_11;
		endcase
	end

	// ==========================================
	// Next state
	always_comb begin
		logic [4:0] hit;
		logic signed [11:0] err;
		logic [10:0] tgt;
		logic [11:0] sum3;
		logic [18:0] prod;
		logic [9:0] mean;
		logic [9:0] tol;
		logic tick;
		hit = addr_lookup(reg_addr);
		err = 12'sh000;
		tgt = 11'h000;
		sum3 = 12'h000;
		prod = 19'h00000;
		mean = 10'h000;
		tol = 10'h000;
		tick = 1'b0;
		next_state = state;
		next_state.pin_meta = clamp_pin;
		next_state.pin_sync = state.pin_meta;
		next_state.clamp_prev = clamp_now;
		next_state.rdata = hit[4] ? state.regs[hit[3:0]] : 8'h00;
		if (reg_wr && hit[4]) begin
			next_state.regs[hit[3:0]] = reg_wdata;
		end
		if (clamp_end) begin
			tick = state.lines >= interval - 9'h001;
			next_state.lines = tick ? 9'h000 : state.lines + 9'h001;
		end
		unique case (state.st)
			cal_pkg::st_idle: begin
				if (clamp_end && tick && (off_run || gain_run)) begin
					next_state.st = cal_pkg::st_window;
					next_state.cnt = 4'h0;
					next_state.run_off = off_run;
					next_state.run_gain = gain_run;
				end
			end
			cal_pkg::st_window: begin
				next_state.cnt = state.cnt + 4'h1;
				if (state.cnt == cal_pkg::cal_cycles_last) begin
					next_state.st = cal_pkg::st_apply;
				end
			end
			cal_pkg::st_apply: begin
				next_state.st = cal_pkg::st_idle;
				for (int c = 0; c < 3; c++) begin
					tgt = target_code(state.regs[2*c], state.regs[2*c+1]);
					err = $signed({tgt[10], tgt})
						- $signed({2'b00, avg_bus.avg[c]});
					if (state.run_off && off_run) begin
						next_state.off_auto[c] = sat11($signed({
							{2{state.off_auto[c][10]}}, state.off_auto[c]})
							+ $signed({err[11], err}) / 13'sd2);
					end
				end
				sum3 = {2'b00, avg_bus.avg[0]} + {2'b00, avg_bus.avg[1]}
					+ {2'b00, avg_bus.avg[2]};
				prod = {7'h00, sum3} * 19'h00055;
				mean = prod[17:8];
				tol = {7'h00, mean[9:7]} + 10'h001;
				for (int c = 0; c < 3; c++) begin
					if (state.run_gain && gain_run) begin
						if (avg_bus.avg[c] > mean + tol
								&& state.gain[c] != 8'h81) begin
							next_state.gain[c] = state.gain[c] - 8'h01;
						end else if (avg_bus.avg[c] + tol < mean
								&& state.gain[c] != 8'h7f) begin
							next_state.gain[c] = state.gain[c] + 8'h01;
						end
					end
				end
			end
			default: next_state.st = cal_pkg::st_idle;
		endcase
		for (int c = 0; c < 3; c++) begin
			next_state.off_out[c] = off_enabled ? next_state.off_auto[c]
				: manual_code(next_state.regs[2*c], next_state.regs[2*c+1]);
			if (!freeze) begin
				next_state.dout[c] = adc_data[c];
			end
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			state <= '0;
			state.st <= cal_pkg::st_idle;
		end else begin
			state <= next_state;
		end
	end

	// ==========================================
	// Averager and outputs
	// A clamp end inside a window must not wipe the running sums
	assign avg_bus.clear = clamp_end && state.st == cal_pkg::st_idle;
	assign avg_bus.accumulate = state.st == cal_pkg::st_window;

	chan_average averager (
		.clock(clock),
		.sys_rst(sys_rst),
		.adc_data(adc_data),
		.bus(avg_bus.ctrl)
	);

	assign reg_rdata = state.rdata;
	assign data_out = state.dout;
	assign offset_adj = state.off_out;
	assign gain_trim = state.gain;
	assign clamp_midscale =
		state.regs[cal_pkg::idx_clamp_sel][cal_pkg::clamp_mid_lsb +: 3];
	assign clamp_active = clamp_now;
	assign cal_busy = state.st != cal_pkg::st_idle;

	// ==========================================
	// Checks
	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);

	chk_window_length: assert property (
		state.st == cal_pkg::st_idle && clamp_end && (off_run || gain_run)
		&& state.lines >= interval - 9'h001
		|=> cal_busy ##15 state.st == cal_pkg::st_window
		##1 state.st == cal_pkg::st_apply)
		else $error("calibration window is not sixteen clocks");
	chk_data_frozen: assert property (
		freeze |=> data_out == $past(data_out))
		else $error("data outputs moved during gain matching");
	chk_manual_offset: assert property (
		!off_enabled && $stable(state.regs) |=> !off_enabled |->
		offset_adj[0] == manual_code(state.regs[0], state.regs[1]))
		else $error("manual offset not taken from registers");
	chk_offset_hold: assert property (
		!off_run ##1 !off_run |-> $stable(state.off_auto))
		else $error("offset updated while held or disabled");
	chk_gain_hold: assert property (
		!gain_run ##1 !gain_run |-> $stable(gain_trim))
		else $error("gain trim updated while held or disabled");
	chk_gain_code: assert property (
		(gain_ctl[2:0] != cal_pkg::gain_enable_code) [*2]
		|-> $stable(gain_trim))
		else $error("gain trim moved without enable pattern");
	chk_offset_apply: assert property (
		$changed(state.off_auto) |-> $past(state.st) == cal_pkg::st_apply)
		else $error("auto offset changed outside apply step");
	chk_clamp_source: assert property (
		state.regs[cal_pkg::idx_clamp_sel][cal_pkg::clamp_src_bit]
		&& $past(clamp_pin, 2) && $past(clamp_pin, 1)
		|-> clamp_active)
		else $error("external clamp pin not followed");
	chk_apply_ends: assert property (
		state.st == cal_pkg::st_apply |=> !cal_busy)
		else $error("calibration did not end after apply step");
	chk_gain_apply: assert property (
		$changed(gain_trim) |-> $past(state.st) == cal_pkg::st_apply)
		else $error("gain trim changed outside apply step");
	chk_lines_range: assert property (
		state.lines < 9'h100)
		else $error("clamp interval counter ran past its limit");
endmodule : auto_offset_gain_calibration
`default_nettype wire

// ---- core/chan_average.sv ----
// Sixteen-sample back-porch averager for the three converter channels
`timescale 1ns/10ps
`default_nettype none
module chan_average (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic [2:0][9:0] adc_data,
	cal_avg_if.unit bus
);
	typedef struct packed {
		logic [2:0][13:0] sum;
	} avg_state_t;

	avg_state_t state;
	avg_state_t next_state;

	// ==========================================
	// Accumulate
	always_comb begin
		next_state = state;
		for (int c = 0; c < 3; c++) begin
			if (bus.clear) begin
				next_state.sum[c] = 14'h0000;
			end else if (bus.accumulate) begin
				next_state.sum[c] = state.sum[c] + {4'h0, adc_data[c]};
			end
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	// Exactly sixteen samples, so the mean is a plain shift
	always_comb begin
		for (int c = 0; c < 3; c++) begin
			bus.avg[c] = state.sum[c][13:4];
		end
	end
endmodule : chan_average
`default_nettype wire

// ---- inc/cal_avg_if.sv ----
// Link between the calibration sequencer and the channel averager
`timescale 1ns/10ps
`default_nettype none
interface cal_avg_if;
	logic clear;
	logic accumulate;
	logic [2:0][9:0] avg;
	modport ctrl (output clear, output accumulate, input avg);
	modport unit (input clear, input accumulate, output avg);
endinterface : cal_avg_if
`default_nettype wire

// ---- inc/cal_pkg.sv ----
// Constants and types shared by the offset and gain calibration block
package cal_pkg;

	// ==========================================
	// Register offsets
	localparam logic [7:0] red_target_upper_addr = 8'h0b;
	localparam logic [7:0] red_target_lower_addr = 8'h0c;
	localparam logic [7:0] green_target_upper_addr = 8'h0d;
	localparam logic [7:0] green_target_lower_addr = 8'h0e;
	localparam logic [7:0] blue_target_upper_addr = 8'h0f;
	localparam logic [7:0] blue_target_lower_addr = 8'h10;
	localparam logic [7:0] clamp_select_control_addr = 8'h18;
	localparam logic [7:0] offset_calibration_control_addr = 8'h1b;
	localparam logic [7:0] offset_hold_control_addr = 8'h2c;
	localparam logic [7:0] gain_matching_control_addr = 8'h3c;

	localparam int reg_count = 10;
	localparam logic [reg_count-1:0][7:0] reg_addr_map = {
		gain_matching_control_addr, offset_hold_control_addr,
		offset_calibration_control_addr, clamp_select_control_addr,
		blue_target_lower_addr, blue_target_upper_addr,
		green_target_lower_addr, green_target_upper_addr,
		red_target_lower_addr, red_target_upper_addr};

	// ==========================================
	// Register indices and field positions
	localparam int idx_clamp_sel = 6;
	localparam int idx_off_ctl = 7;
	localparam int idx_off_hold = 8;
	localparam int idx_gain_ctl = 9;
	localparam int clamp_src_bit = 4;
	localparam int clamp_mid_lsb = 1;
	localparam int auto_offset_bit = 5;
	localparam int rate_lsb = 3;
	localparam int offset_hold_bit = 4;
	localparam int gain_hold_bit = 3;
	localparam logic [2:0] gain_enable_code = 3'b110;
	localparam logic [7:0] reg_reset = 8'h00;

	// ==========================================
	// Timing in data clocks and clamp intervals
	localparam logic [3:0] cal_cycles_last = 4'hf;
	localparam logic [8:0] interval_00 = 9'h010;
	localparam logic [8:0] interval_01 = 9'h040;
	localparam logic [8:0] interval_10 = 9'h0c0;
	localparam logic [8:0] interval_11 = 9'h100;

	typedef enum logic [2:0] {
		st_idle = 3'b001,
		st_window = 3'b010,
		st_apply = 3'b100
	} cal_state_t;

endpackage : cal_pkg

// ---- verif/auto_offset_gain_calibration_bench.sv ----
// Self-checking bench for the offset and gain calibration block
`timescale 1ns/10ps
`default_nettype none
module auto_offset_gain_calibration_bench;
	logic clock = 1'b0;
	logic sys_rst = 1'b1;
	logic reg_wr;
	logic [7:0] reg_addr, reg_wdata, reg_rdata;
	logic clamp_pin = 1'b0;
	logic clamp_internal = 1'b0;
	logic [2:0][9:0] adc_data = '0;
	logic [2:0][9:0] data_out;
	logic [2:0][10:0] offset_adj;
	logic [2:0][7:0] gain_trim;
	logic [2:0] clamp_midscale;
	logic clamp_active, cal_busy;
	int error_cnt = 0;
	int check_count = 0;
	int raw [3] = '{100, 100, 100};

	always #25 clock = ~clock;

	auto_offset_gain_calibration i_dut (.clock(clock), .sys_rst(sys_rst),
		.reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .clamp_pin(clamp_pin),
		.clamp_internal(clamp_internal), .adc_data(adc_data),
		.data_out(data_out), .offset_adj(offset_adj), .gain_trim(gain_trim),
		.clamp_midscale(clamp_midscale), .clamp_active(clamp_active),
		.cal_busy(cal_busy));

	host_model i_host (.clock(clock), .reg_rdata(reg_rdata), .reg_wr(reg_wr),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata));

	// ==========================================
	// Helpers
	task automatic end_sim();
		if (error_cnt == 0 && check_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : end_sim

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	// Converter model: raw level shifted by the offset, clipped
	function automatic logic [9:0] conv(input int r, input logic [10:0] off);
		int v;
		v = r + int'($signed(off));
		if (v < 0) v = 0;
		if (v > 1023) v = 1023;
		return v[9:0];
	endfunction : conv

	// Data toggles every cycle so a missed freeze shows
	task automatic clamp_pulse(input logic ext, input logic gain, output int nb);
		logic [2:0][9:0] held;
		int first;
		nb = 0;
		first = 0;
		held = '0;
		for (int k = 0; k < 30; k++) begin
			@(negedge clock);
			if (cal_busy === 1'b1) begin
				if (nb == 0) begin
					first = k;
					held = data_out;
				end else if (gain && nb < 16) begin
					chk(data_out, held);
				end
				nb++;
			end
			clamp_pin = ext && k < 4;
			clamp_internal = !ext && k < 4;
			for (int i = 0; i < 3; i++) begin
				adc_data[i] = conv(raw[i] + k % 2, offset_adj[i]);
			end
		end
		if (nb > 0 && !ext) chk(first, 5);
	endtask : clamp_pulse

	task automatic wait_cal(input logic ext, input logic gain, input int lim,
		output int n, output int nb);
		n = 0;
		nb = 0;
		while (nb == 0 && n < lim) begin
			clamp_pulse(ext, gain, nb);
			n++;
		end
	endtask : wait_cal

	// ==========================================
	// Scenarios
	task automatic t_regs();
		logic [7:0] d, a;
		for (int i = 0; i < cal_pkg::reg_count; i++) begin
			a = cal_pkg::reg_addr_map[i];
			i_host.read_reg(a, d);
			chk(d, cal_pkg::reg_reset);
			i_host.write_reg(a, a ^ 8'ha5);
			i_host.read_reg(a, d);
			chk(d, a ^ 8'ha5);
		end
		i_host.write_reg(8'h55, 8'h3c);
		i_host.read_reg(8'h55, d);
		chk(d, 8'h00);
		for (int i = 6; i < 10; i++) i_host.write_reg(cal_pkg::reg_addr_map[i], 8'h00);
	endtask : t_regs

	task automatic t_manual();
		i_host.write_reg(8'h0b, 8'hbf);
		i_host.write_reg(8'h0c, 8'hc0);
		i_host.write_reg(8'h0d, 8'h7f);
		i_host.write_reg(8'h0e, 8'h40);
		repeat (3) @(negedge clock);
		chk(offset_adj[0], 11'h0ff);
		chk(offset_adj[1], 11'h7fd);
	endtask : t_manual

	task automatic t_clamp();
		logic [2:0] c [3] = '{3'b000, 3'b101, 3'b010};
		for (int i = 0; i < 3; i++) begin
			i_host.write_reg(8'h18, {4'h0, c[i], 1'b0});
			repeat (2) @(negedge clock);
			chk(clamp_midscale, c[i]);
		end
		i_host.write_reg(8'h18, 8'h10);
		clamp_internal = 1'b1;
		repeat (4) @(negedge clock);
		chk(clamp_active, 1'b0);
		clamp_pin = 1'b1;
		repeat (4) @(negedge clock);
		chk(clamp_active, 1'b1);
		clamp_pin = 1'b0;
		i_host.write_reg(8'h18, 8'h00);
		repeat (2) @(negedge clock);
		chk(clamp_active, 1'b1);
		clamp_internal = 1'b0;
	endtask : t_clamp

	task automatic t_rate();
		logic [8:0] iv [4] = '{cal_pkg::interval_00, cal_pkg::interval_01,
			cal_pkg::interval_10, cal_pkg::interval_11};
		int n, nb;
		for (int r = 0; r < 4; r++) begin
			i_host.write_reg(8'h1b, {2'b00, 1'b1, 2'(r), 3'b000});
			wait_cal(1'b0, 1'b0, 300, n, nb);
			chk(nb, 17);
			wait_cal(1'b0, 1'b0, 300, n, nb);
			chk(n, iv[r]);
		end
	endtask : t_rate

	task automatic t_auto();
		int n, nb, e;
		logic [7:0] d;
		int tgt [3] = '{512, 4, 512};
		raw = '{400, 60, 450};
		for (int i = 0; i < 3; i++) i_host.write_target(i, 11'(tgt[i]));
		i_host.read_reg(8'h0b, d);
		chk(d, 8'h40);
		i_host.read_reg(8'h0e, d);
		chk(d, 8'h80);
		i_host.write_reg(8'h18, 8'h1a);
		i_host.write_reg(8'h1b, 8'h20);
		repeat (12) begin
			wait_cal(1'b1, 1'b0, 40, n, nb);
			chk(nb, 17);
		end
		for (int i = 0; i < 3; i++) begin
			e = int'(data_out[i]) - tgt[i];
			chk(e <= 2 && e >= -2, 1'b1);
		end
	endtask : t_auto

	task automatic t_hold();
		int n, nb;
		logic [2:0][10:0] kept;
		logic [2:0][7:0] trim_exp;
		trim_exp = {8'hff, 8'h01, 8'hff};
		i_host.write_reg(8'h2c, 8'h10);
		i_host.write_reg(8'h18, 8'h0a);
		kept = offset_adj;
		wait_cal(1'b0, 1'b0, 40, n, nb);
		chk(nb, 0);
		for (int i = 0; i < 3; i++) chk(offset_adj[i], kept[i]);
		i_host.write_reg(8'h2c, 8'h00);
		wait_cal(1'b0, 1'b0, 40, n, nb);
		chk(nb, 17);
		i_host.write_reg(8'h1b, 8'h00);
		i_host.write_reg(8'h3c, 8'h06);
		wait_cal(1'b0, 1'b1, 40, n, nb);
		chk(nb, 17);
		chk(gain_trim, trim_exp);
		i_host.write_reg(8'h3c, 8'h0e);
		wait_cal(1'b0, 1'b1, 40, n, nb);
		chk(nb, 0);
		chk(gain_trim, trim_exp);
	endtask : t_hold

	// ==========================================
	// Main sequence and watchdog
	initial begin
		repeat (12) @(negedge clock);
		sys_rst = 1'b0;
		t_regs();
		t_manual();
		t_clamp();
		t_rate();
		t_auto();
		t_hold();
		end_sim();
	end

	// Longest path is the rate sweep, well under this span
	initial begin
		#4500000;
		error_cnt++;
		end_sim();
	end
endmodule : auto_offset_gain_calibration_bench
`default_nettype wire

// ---- verif/host_model.sv ----
// Host model that programs the calibration registers
`timescale 1ns/10ps
`default_nettype none
module host_model (
	input wire logic clock,
	input wire logic [7:0] reg_rdata,
	output logic reg_wr,
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata
);
	initial begin
		reg_wr = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
	end

	// ==========================================
	// Bus cycles
	// Data inverted after the strobe so no stale value is seen
	task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
		@(negedge clock);
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		@(negedge clock);
		reg_wr = 1'b0;
		reg_wdata = ~d;
	endtask : write_reg

	task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
		@(negedge clock);
		reg_addr = a;
		@(negedge clock);
		d = reg_rdata;
	endtask : read_reg

	task automatic write_target(input int ch, input logic [10:0] code);
		if (code != 11'h000) begin
			write_reg(8'h0b + 8'(2 * ch), code[10:3]);
			write_reg(8'h0c + 8'(2 * ch), {code[2:0], 5'h00});
		end
	endtask : write_target
endmodule : host_model
`default_nettype wire
